// File: src/srf_cfg.svh
`ifndef SRF_CFG_SVH
`define SRF_CFG_SVH

// Register offsets (byte addresses)
`define SRF_OFF_CTRL     8'h00
`define SRF_OFF_SLICE    8'h04
`define SRF_OFF_TSTAMP   8'h08
`define SRF_OFF_SSRC     8'h0c
`define SRF_OFF_LEN      8'h10
`define SRF_OFF_STATUS   8'h14

// Control and status register fields
`define SRF_CTRL_START   0
`define SRF_CTRL_LAST    1
`define SRF_CTRL_PIC     2
`define SRF_CTRL_SLC     3
`define SRF_CTRL_BUSY    8
`define SRF_STAT_ERR     16

// Reset values
`define SRF_RST_WORD     32'h0000_0000
`define SRF_RST_SEQ      16'h0000

// Packet header layout
`define SRF_PH_PIC       31
`define SRF_PH_SLC       30
`define SRF_PH_RES_HI    29
`define SRF_PH_RES_LO    25
`define SRF_PH_MB_HI     24
`define SRF_PH_MB_LO     10
`define SRF_PH_ID_HI     9
`define SRF_PH_ID_LO     0

// RTP fixed fields: version 2, no padding, extension or sources
`define SRF_RTP_VER      2'h2
`define SRF_RTP_PT       7'h00
`define SRF_RTP_BYTE0    8'h80

// Framing counts
`define SRF_HEAD_LAST    5'h13
`define SRF_HEAD_TAIL    16'h0010
`define SRF_POP_MAXBYTES 10'h200
`define SRF_POS_BODY     5'h1f
`define SRF_FIFO_DEPTH   8

`endif

// File: src/srf_pkg.sv
package srf_pkg;

  // Partition data type codes
  typedef enum logic [3:0] {
    SRF_PT_HEADER = 4'h0,
    SRF_PT_MBHDR  = 4'h1,
    SRF_PT_MVD    = 4'h2,
    SRF_PT_EOS    = 4'h3,
    SRF_PT_CBP    = 4'h4,
    SRF_PT_CDC    = 4'h5,
    SRF_PT_LUMA   = 4'h6,
    SRF_PT_CHROMA = 4'h7
  } srf_part_type;

  // One FIFO word: a record header (type, length) or one payload byte
  typedef struct packed {
    logic        hdr;
    logic [15:0] data;
  } srf_word_type;

  typedef enum logic [1:0] {
    SRF_IDLE = 2'b00,
    SRF_HEAD = 2'b01,
    SRF_BODY = 2'b11,
    SRF_NEXT = 2'b10
  } srf_state_type;

endpackage

// File: src/srf_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "srf_cfg.svh"

module srf_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
      end
      if (pop)
      begin
        rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
      end
      // Ready is registered so the source sees a clean, glitch-free stall
      case ({push, pop})
        2'b10:
        begin
          count_r  <= (AW+1)'(count_r + 1'b1);
          in_ready <= (count_r != (AW+1)'(DEPTH - 1));
        end
        2'b01:
        begin
          count_r  <= (AW+1)'(count_r - 1'b1);
          in_ready <= 1'b1;
        end
        default:
        begin
          count_r  <= count_r;
        end
      endcase
    end
  end
endmodule

// Contract
// - Exactly two packets emitted per slice
// - First packet: headers, modes, motion, end
// - Second packet: pattern, DC, luma, chroma
// - Payload opens with 32-bit packet header
// - Bit 31 flags picture header
// - Bit 30 flags slice header, 25-29 reserved
// - Bits 24..10 carry first macroblock index
// - Bits 9..0 carry slice identifier
// - Record header bits 15..12 hold type
// - Bits 11..0 length in bits, zero=4096
// - Timestamp in 90 kHz units
// - Marker only on slice's last second packet
// - Sequence starts zero, plus one per packet
// - RTP version 2, P X CC PT zero
// - Payload directly follows RTP header
// - Each packet preceded by 32-bit byte size
module srf_framer (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // Partition stream from the encoder
  input  wire logic                 part_valid,
  input  wire srf_pkg::srf_word_type part_word,
  output logic                      part_ready,
  // Packet file byte stream
  output logic                      pkt_valid,
  output logic [7:0]                pkt_byte,
  output logic                      pkt_last,
  input  wire logic                 pkt_ready
);
  logic                  rst_meta_r;
  logic                  rst_sync_n;
  logic [3:0]            ctrl_r;
  logic [31:0]           slice_r;
  logic [31:0]           tstamp_r;
  logic [31:0]           ssrc_r;
  logic [31:0]           len_r;
  logic [15:0]           seq_r;
  logic                  err_r;
  srf_pkg::srf_state_type state_r;
  logic                  phase_r;
  logic [4:0]            hidx_r;
  logic [4:0]            pos_r;
  logic [15:0]           body_left_r;
  logic                  lo_pend_r;
  logic [9:0]            rec_left_r;
  logic                  fifo_valid;
  srf_pkg::srf_word_type fifo_word;
  logic                  fifo_pop;
  logic                  adv;
  logic                  start;
  logic                  marker;
  logic                  emit_hi;
  logic                  emit_data;
  logic                  done_pkt;
  logic [15:0]           body_bytes;
  logic [31:0]           pkt_hdr;
  logic [159:0]          head_vec;
  logic [7:0]            head_sel;
  logic                  first_class;
  logic [9:0]            rec_bytes;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  srf_fifo #(
    .WIDTH ($bits(srf_pkg::srf_word_type)),
    .DEPTH (`SRF_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_sync_n),
    .in_valid  (part_valid),
    .in_data   (part_word),
    .in_ready  (part_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (fifo_pop)
  );

  assign adv        = !pkt_valid || pkt_ready;
  assign start      = reg_wr && (reg_addr == `SRF_OFF_CTRL) && reg_wdata[`SRF_CTRL_START] && (state_r == srf_pkg::SRF_IDLE);
  assign body_bytes = phase_r ? len_r[31:16] : len_r[15:0];
  assign marker     = phase_r && ctrl_r[`SRF_CTRL_LAST];
  assign pkt_hdr    = {!phase_r && ctrl_r[`SRF_CTRL_PIC], !phase_r && ctrl_r[`SRF_CTRL_SLC], 5'h00,
                       slice_r[`SRF_PH_MB_HI:`SRF_PH_MB_LO], slice_r[`SRF_PH_ID_HI:`SRF_PH_ID_LO]};
  assign head_vec   = {16'h0000, 16'(body_bytes + `SRF_HEAD_TAIL), `SRF_RTP_BYTE0, marker, `SRF_RTP_PT,
                       seq_r, tstamp_r, ssrc_r, pkt_hdr};
  assign head_sel   = 8'(8'h9f - {hidx_r, 3'h0});
  assign emit_hi    = (state_r == srf_pkg::SRF_BODY) && adv && fifo_valid && fifo_word.hdr && !lo_pend_r;
  assign emit_data  = (state_r == srf_pkg::SRF_BODY) && adv && fifo_valid && (!fifo_word.hdr || lo_pend_r);
  assign fifo_pop   = emit_data;
  assign done_pkt   = (state_r == srf_pkg::SRF_NEXT) && adv;
  assign first_class = (fifo_word.data[15:12] <= 4'(srf_pkg::SRF_PT_EOS));
  assign rec_bytes  = (fifo_word.data[11:0] == 12'h000) ? `SRF_POP_MAXBYTES :
                      10'(({1'b0, fifo_word.data[11:0]} + 13'h0007) >> 3);

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_r   <= 4'h0;
      slice_r  <= `SRF_RST_WORD;
      tstamp_r <= `SRF_RST_WORD;
      ssrc_r   <= `SRF_RST_WORD;
      len_r    <= `SRF_RST_WORD;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        // Control is latched only while idle; slice, timestamp, SSRC and length registers take writes at any time
        `SRF_OFF_CTRL:
        begin
          if (state_r == srf_pkg::SRF_IDLE)
          begin
            ctrl_r <= reg_wdata[3:0];
          end
        end
        `SRF_OFF_SLICE:  slice_r  <= reg_wdata;
        `SRF_OFF_TSTAMP: tstamp_r <= reg_wdata;
        `SRF_OFF_SSRC:   ssrc_r   <= reg_wdata;
        `SRF_OFF_LEN:    len_r    <= reg_wdata;
        default:         ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `SRF_OFF_CTRL:   reg_rdata <= {23'h000000, state_r != srf_pkg::SRF_IDLE, 4'h0, ctrl_r};
        `SRF_OFF_SLICE:  reg_rdata <= slice_r;
        `SRF_OFF_TSTAMP: reg_rdata <= tstamp_r;
        `SRF_OFF_SSRC:   reg_rdata <= ssrc_r;
        `SRF_OFF_LEN:    reg_rdata <= len_r;
        `SRF_OFF_STATUS: reg_rdata <= {15'h0000, err_r, seq_r};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Packet sequencer and output byte
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r     <= srf_pkg::SRF_IDLE;
      phase_r     <= 1'b0;
      hidx_r      <= 5'h00;
      pos_r       <= `SRF_POS_BODY;
      body_left_r <= 16'h0000;
      lo_pend_r   <= 1'b0;
      pkt_valid   <= 1'b0;
      pkt_byte    <= 8'h00;
      pkt_last    <= 1'b0;
    end
    else
    begin
      case (state_r)
        srf_pkg::SRF_IDLE:
        begin
          if (adv)
          begin
            pkt_valid <= 1'b0;
          end
          if (start)
          begin
            phase_r <= 1'b0;
            hidx_r  <= 5'h00;
            state_r <= srf_pkg::SRF_HEAD;
          end
        end
        srf_pkg::SRF_HEAD:
        begin
          if (adv)
          begin
            pkt_valid   <= 1'b1;
            pkt_byte    <= head_vec[head_sel -: 8];
            pos_r       <= hidx_r;
            pkt_last    <= (hidx_r == `SRF_HEAD_LAST) && (body_bytes == 16'h0000);
            hidx_r      <= 5'(hidx_r + 1'b1);
            body_left_r <= body_bytes;
            if (hidx_r == `SRF_HEAD_LAST)
            begin
              state_r <= (body_bytes == 16'h0000) ? srf_pkg::SRF_NEXT : srf_pkg::SRF_BODY;
            end
          end
        end
        srf_pkg::SRF_BODY:
        begin
          if (adv)
          begin
            pos_r <= `SRF_POS_BODY;
            // Output bubbles while the encoder is slower than the link
            pkt_valid <= fifo_valid;
            pkt_last  <= fifo_valid && (body_left_r == 16'h0001);
            if (fifo_valid)
            begin
              pkt_byte    <= emit_hi ? fifo_word.data[15:8] : fifo_word.data[7:0];
              lo_pend_r   <= emit_hi;
              body_left_r <= 16'(body_left_r - 1'b1);
              if (body_left_r == 16'h0001)
              begin
                state_r <= srf_pkg::SRF_NEXT;
              end
            end
          end
        end
        srf_pkg::SRF_NEXT:
        begin
          if (adv)
          begin
            pkt_valid <= 1'b0;
            pkt_last  <= 1'b0;
            hidx_r    <= 5'h00;
            lo_pend_r <= 1'b0;
            // second packet always follows the first
            if (!phase_r)
            begin
              phase_r <= 1'b1;
              state_r <= srf_pkg::SRF_HEAD;
            end
            else
            begin
              state_r <= srf_pkg::SRF_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= srf_pkg::SRF_IDLE;
        end
      endcase
    end
  end

  // sequence from zero, one per packet
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      seq_r <= `SRF_RST_SEQ;
    end
    else if (done_pkt)
    begin
      seq_r <= 16'(seq_r + 1'b1);
    end
  end

  // record length tracking and error flag
  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rec_left_r <= 10'h000;
      err_r      <= 1'b0;
    end
    else
    begin
      if (emit_hi)
      begin
        rec_left_r <= rec_bytes;
      end
      else if (emit_data && !fifo_word.hdr)
      begin
        rec_left_r <= 10'(rec_left_r - 1'b1);
      end
      // Set wins over a software clear in the same cycle
      if ((emit_hi && ((rec_left_r != 10'h000) || (first_class == phase_r))) ||
          (emit_data && !fifo_word.hdr && (rec_left_r == 10'h000)))
      begin
        err_r <= 1'b1;
      end
      else if (reg_wr && (reg_addr == `SRF_OFF_STATUS) && reg_wdata[`SRF_STAT_ERR])
      begin
        err_r <= 1'b0;
      end
    end
  end

  rtp_version_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h04) |-> pkt_byte == `SRF_RTP_BYTE0)
    else $error("RTP first byte wrong");
  marker_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h05) |-> (pkt_byte == {phase_r && ctrl_r[`SRF_CTRL_LAST], 7'h00}))
    else $error("Marker or payload type wrong");
  pic_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h10) |-> pkt_byte[7] == (!phase_r && ctrl_r[`SRF_CTRL_PIC]))
    else $error("Picture flag wrong");
  slice_res_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h10) |-> (pkt_byte[6] == (!phase_r && ctrl_r[`SRF_CTRL_SLC])) && (pkt_byte[5:1] == 5'h00))
    else $error("Slice flag or reserved bits wrong");
  slice_id_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h13) |-> pkt_byte == slice_r[7:0])
    else $error("Slice identifier low byte wrong");
  size_prefix_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    pkt_valid && (pos_r == 5'h03) |-> pkt_byte == 8'(body_bytes + `SRF_HEAD_TAIL))
    else $error("Size prefix wrong");
  seq_step_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    done_pkt |=> seq_r == 16'($past(seq_r) + 1'b1))
    else $error("Sequence did not step by one");
  two_packets_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    done_pkt && !phase_r |=> phase_r && (state_r == srf_pkg::SRF_HEAD))
    else $error("Second packet not started");
  zero_len_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    emit_hi && (fifo_word.data[11:0] == 12'h000) |=> rec_left_r == 10'h200)
    else $error("Zero length not taken as 4096 bits");
endmodule

`default_nettype wire

// File: testbench/srf_sink.sv
`timescale 1ns/1ps
`default_nettype none

module srf_sink (
  // Clock
  input  wire logic       sys_clk,
  // Pacing chosen by the bench
  input  wire logic       stall,
  // Packet byte stream
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_byte,
  input  wire logic       pkt_last,
  output var  logic       pkt_ready
);
  logic [7:0] got_byte [$];
  logic       got_last [$];

  initial pkt_ready = 1'b0;

  // Slow mode accepts on every other edge, so held bytes get exercised
  always @(posedge sys_clk)
  begin
    if (pkt_valid === 1'b1 && pkt_ready)
    begin
      got_byte.push_back(pkt_byte);
      got_last.push_back(pkt_last);
    end
    pkt_ready <= stall ? ~pkt_ready : 1'b1;
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "srf_cfg.svh"

module testbench;
  logic                  sys_clk;
  logic                  rstn;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [31:0]           reg_rdata;
  logic                  part_valid;
  srf_pkg::srf_word_type part_word;
  logic                  part_ready;
  logic                  pkt_valid;
  logic [7:0]            pkt_byte;
  logic                  pkt_last;
  logic                  pkt_ready;
  logic                  stall;
  int                    err_total;
  int                    compares;
  logic [7:0]            exp_q [$];
  srf_pkg::srf_word_type word_q [$];

  srf_framer u_dut (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .part_valid (part_valid),
    .part_word  (part_word),
    .part_ready (part_ready),
    .pkt_valid  (pkt_valid),
    .pkt_byte   (pkt_byte),
    .pkt_last   (pkt_last),
    .pkt_ready  (pkt_ready)
  );

  srf_sink u_sink (
    .sys_clk   (sys_clk),
    .stall     (stall),
    .pkt_valid (pkt_valid),
    .pkt_byte  (pkt_byte),
    .pkt_last  (pkt_last),
    .pkt_ready (pkt_ready)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
  begin
    compares++;
    if (seen !== want)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  end
  endtask

  task automatic wrap_up;
  begin
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
  begin
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  end
  endtask

  task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
  begin
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    data = reg_rdata;
  end
  endtask

  // Holds the word until an edge sees ready high; bounded so a stuck buffer cannot hang
  task automatic push_word(input srf_pkg::srf_word_type w);
    logic ok;
    int   n;
  begin
    @(posedge sys_clk);
    part_valid <= 1'b1;
    part_word  <= w;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 4000)
    begin
      #1;
      ok = (part_ready === 1'b1);
      @(posedge sys_clk);
      n++;
    end
    part_valid <= 1'b0;
    check({31'h0, ok}, 32'h1, "word accepted");
  end
  endtask

  function automatic srf_pkg::srf_word_type hw(input srf_pkg::srf_part_type t, input logic [11:0] len);
    return {1'b1, t, len};
  endfunction

  function automatic srf_pkg::srf_word_type bw(input logic [7:0] b);
    return {1'b0, 8'h00, b};
  endfunction

  task automatic put8(input logic [7:0] v);
  begin
    exp_q.push_back(v);
  end
  endtask

  task automatic put16(input logic [15:0] v);
  begin
    put8(v[15:8]);
    put8(v[7:0]);
  end
  endtask

  task automatic put32(input logic [31:0] v);
  begin
    put16(v[31:16]);
    put16(v[15:0]);
  end
  endtask

  task automatic reset_values;
    logic [31:0] rd;
  begin
    reg_read(`SRF_OFF_STATUS, rd);
    check(rd, 32'h0, "status after reset");
    reg_read(`SRF_OFF_CTRL, rd);
    check(rd, 32'h0, "control after reset");
    reg_write(8'h18, 32'hffff_ffff);
    reg_read(8'h18, rd);
    check(rd, 32'h0, "unmapped read");
  end
  endtask

  // One slice: seven words for the first packet, two for the second
  task automatic run_slice(input logic last, input logic pic, input logic slc, input logic [14:0] mb,
                           input logic [9:0] id, input logic [31:0] ts, input logic [31:0] ssrc,
                           input srf_pkg::srf_part_type t0, input srf_pkg::srf_part_type t1,
                           input srf_pkg::srf_part_type t2, input logic [7:0] seed,
                           input logic [15:0] seq, input logic slow);
    logic [31:0] rd;
    int          n;
  begin
    exp_q.delete();
    u_sink.got_byte.delete();
    u_sink.got_last.delete();
    stall <= slow;
    word_q = '{hw(t0, 12'h010), bw(seed), bw(seed + 8'h01), hw(t1, 12'h011), bw(seed + 8'h02),
               bw(seed + 8'h03), bw(seed + 8'h04), hw(t2, 12'h008), bw(seed + 8'h05)};
    for (int p = 0; p < 2; p++)
    begin
      put32(p == 0 ? 32'h0000_0019 : 32'h0000_0013);
      put8(`SRF_RTP_BYTE0);
      put8({p == 1 && last, `SRF_RTP_PT});
      put16(seq + 16'(p));
      put32(ts);
      put32(ssrc);
      put32({p == 0 && pic, p == 0 && slc, 5'h00, mb, id});
      for (int i = (p == 1 ? 7 : 0); i < (p == 1 ? 9 : 7); i++)
        if (word_q[i].hdr) put16(word_q[i].data); else put8(word_q[i].data[7:0]);
    end
    reg_write(`SRF_OFF_SLICE, {7'h00, mb, id});
    reg_write(`SRF_OFF_TSTAMP, ts);
    reg_write(`SRF_OFF_SSRC, ssrc);
    // both packets kept far below any transfer unit
    reg_write(`SRF_OFF_LEN, 32'h0003_0009);
    for (int i = 0; i < 8; i++)
      push_word(word_q[i]);
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, part_ready}, 32'h0, "full buffer refuses");
    reg_write(`SRF_OFF_CTRL, {28'h0, slc, pic, last, 1'b1});
    fork
      push_word(word_q[8]);
      reg_read(`SRF_OFF_CTRL, rd);
    join
    check(rd & 32'h100, 32'h100, "busy while sending");
    n = 0;
    while (u_sink.got_byte.size() < exp_q.size() && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    check(u_sink.got_byte.size(), exp_q.size(), "byte count");
    for (int i = 0; i < exp_q.size(); i++)
    begin
      check(u_sink.got_byte[i], exp_q[i], "packet byte");
      check(u_sink.got_last[i], (i == 28 || i == exp_q.size() - 1), "last flag");
    end
    reg_read(`SRF_OFF_STATUS, rd);
    check(rd, {16'h0000, seq + 16'h0002}, "sequence and error");
  end
  endtask

  // A zero-length record carries 512 bytes; a first-class record in packet two must raise the error flag
  task automatic long_slice;
    logic [31:0] rd;
    int          n;
  begin
    u_sink.got_byte.delete();
    u_sink.got_last.delete();
    stall <= 1'b0;
    reg_write(`SRF_OFF_SLICE, 32'h0000_0001);
    reg_write(`SRF_OFF_LEN, 32'h0003_0202);
    reg_write(`SRF_OFF_CTRL, 32'h0000_0003);
    push_word(hw(srf_pkg::SRF_PT_HEADER, 12'h000));
    for (int i = 0; i < 512; i++)
      push_word(bw(8'(i)));
    push_word(hw(srf_pkg::SRF_PT_MVD, 12'h008));
    push_word(bw(8'h3c));
    n = 0;
    while (u_sink.got_byte.size() < 557 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (4) @(posedge sys_clk);
    check(u_sink.got_byte.size(), 557, "long byte count");
    check(u_sink.got_byte[2], 8'h02, "long size high");
    check(u_sink.got_byte[3], 8'h12, "long size low");
    check(u_sink.got_byte[21], 8'h00, "zero length field");
    check(u_sink.got_byte[533], 8'hff, "last long payload byte");
    check(u_sink.got_last[533], 1'b1, "long first packet end");
    check(u_sink.got_byte[554], 8'h20, "second packet record type");
    check(u_sink.got_last[556], 1'b1, "long second packet end");
    reg_read(`SRF_OFF_STATUS, rd);
    check(rd, 32'h0001_000a, "wrong class flagged");
    reg_write(`SRF_OFF_STATUS, 32'h0001_0000);
    reg_read(`SRF_OFF_STATUS, rd);
    check(rd, 32'h0000_000a, "error flag cleared");
  end
  endtask

  initial
  begin
    rstn       = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    part_valid = 1'b0;
    part_word  = '0;
    stall      = 1'b0;
    err_total  = 0;
    compares   = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_values();
    run_slice(1'b0, 1'b1, 1'b1, 15'h1234, 10'h2a5, 32'h0001_5f90, 32'h1357_9bdf, srf_pkg::SRF_PT_MBHDR,
              srf_pkg::SRF_PT_EOS, srf_pkg::SRF_PT_CBP, 8'h10, 16'h0000, 1'b1);
    run_slice(1'b0, 1'b0, 1'b1, 15'h7fff, 10'h3ff, 32'h0002_bf20, 32'h1357_9bdf, srf_pkg::SRF_PT_HEADER,
              srf_pkg::SRF_PT_MVD, srf_pkg::SRF_PT_LUMA, 8'hf0, 16'h0002, 1'b0);
    run_slice(1'b0, 1'b0, 1'b0, 15'h0000, 10'h000, 32'h0002_bf20, 32'h2468_ace0, srf_pkg::SRF_PT_MVD,
              srf_pkg::SRF_PT_EOS, srf_pkg::SRF_PT_CDC, 8'h5a, 16'h0004, 1'b1);
    run_slice(1'b1, 1'b0, 1'b1, 15'h4001, 10'h201, 32'hffff_fff0, 32'h2468_ace0, srf_pkg::SRF_PT_HEADER,
              srf_pkg::SRF_PT_MBHDR, srf_pkg::SRF_PT_CHROMA, 8'ha0, 16'h0006, 1'b0);
    long_slice();
    wrap_up();
  end

  // Five slices need a few thousand cycles; this leaves ample margin
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule

`default_nettype wire
